// [core/nspc_pkg.sv]
// Package: register map, field positions, encodings and timing for the self-program controller
package nspc_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_KEY = 8'h04;
	localparam logic [7:0] OFF_LATCH = 8'h08;
	localparam logic [7:0] OFF_PTR_LO = 8'h0c;
	localparam logic [7:0] OFF_PTR_HI = 8'h10;
	localparam logic [7:0] OFF_PTR_UP = 8'h14;
	localparam logic [7:0] OFF_TBL_CMD = 8'h18;
	localparam logic [7:0] OFF_IRQ2 = 8'h1c;
	localparam logic [7:0] OFF_STAT = 8'h20;
	// ----------------------------------------
	// Control, table-command and IRQ2 register fields; unlock key values
	// ----------------------------------------
	localparam int CTRL_PSEL = 7;
	localparam int CTRL_CSEL = 6;
	localparam int CTRL_FREE = 4;
	localparam int CTRL_ABORT = 3;
	localparam int CTRL_PERMIT = 2;
	localparam int CTRL_WR = 1;
	localparam int CTRL_RD = 0;
	localparam logic ABORT_RESET = 1'b1;
	localparam int IRQ2_DONE = 0;
	localparam int CMD_DIR = 0;
	localparam int CMD_MODE_LO = 1;
	localparam int CMD_MODE_HI = 2;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	// ----------------------------------------
	// Pointer and block geometry
	// ----------------------------------------
	localparam int PTR_W = 22;
	localparam int PTR_LOW_W = 21;
	localparam int HOLD_BYTES = 16;
	localparam int HOLD_IDX_W = 4;
	localparam logic [7:0] HOLD_RESET = 8'hff;
	localparam logic [21:0] ERASE_MASK = 22'h3fffc0;
	localparam logic [21:0] WRITE_MASK = 22'h3ffff0;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int PROG_TIME_US = 2000;
	localparam int CLK_MHZ = 200;
	localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_READ = 2'b01, ST_LONG = 2'b10} nspc_state_type;
	typedef enum logic [1:0] {PM_NONE = 2'b00, PM_POSTINC = 2'b01, PM_POSTDEC = 2'b10, PM_PREINC = 2'b11} nspc_mode_type;
	typedef enum logic [1:0] {TGT_EEPROM = 2'b00, TGT_PROGRAM = 2'b01, TGT_CONFIG = 2'b10} nspc_target_type;
endpackage

// [core/nspc_hold_if.sv]
// Interface: holding-register write port and block view
`timescale 1ns/1ps
`default_nettype none
interface nspc_hold_if;
	import nspc_pkg::*;
	logic write_permit;
	logic [HOLD_IDX_W-1:0] wrIdx;
	logic [7:0] wrData;
	logic clearAll;
	logic [HOLD_BYTES*8-1:0] block;
	modport ctrl(output write_permit, output wrIdx, output wrData, output clearAll, input block);
	modport regs(input write_permit, input wrIdx, input wrData, input clearAll, output block);
endinterface
`default_nettype wire

// [core/nspc_hold_regs.sv]
// Write-block holding registers
`timescale 1ns/1ps
`default_nettype none
module nspc_hold_regs import nspc_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	nspc_hold_if.regs hold
);
	logic [7:0] bytes_r [HOLD_BYTES];

	always_ff @(posedge sys_clk or posedge rst) begin
		for (int i = 0; i < HOLD_BYTES; i++) begin
			if (rst) begin
				bytes_r[i] <= HOLD_RESET; // [RL20]
			end else if (hold.clearAll) begin
				bytes_r[i] <= HOLD_RESET; // [RL20]
			end else if (hold.write_permit && hold.wrIdx == HOLD_IDX_W'(i)) begin
				bytes_r[i] <= hold.wrData; // [RL15]
			end
		end
	end

	for (genvar g = 0; g < HOLD_BYTES; g++) begin : gView
		assign hold.block[g*8 +: 8] = bytes_r[g];
	end

	hold_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL20]
		hold.clearAll |=> bytes_r[0] == HOLD_RESET && bytes_r[HOLD_BYTES-1] == HOLD_RESET)
		else $error("holding registers not reset to all ones");
endmodule
`default_nettype wire

// [core/nspc_prog_timer.sv]
// Self-timed programming timer
`timescale 1ns/1ps
`default_nettype none
module nspc_prog_timer import nspc_pkg::*; #(
	parameter int unsigned CYCLES = PROG_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	output logic busy,
	output logic done
);
	localparam int CNT_W = $clog2(CYCLES + 1);
	logic [CNT_W-1:0] count_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_r <= '0;
		end else if (start && count_r == '0) begin
			count_r <= CNT_W'(CYCLES); // [RL22]
		end else if (count_r != '0) begin
			count_r <= count_r - CNT_W'(1);
		end
	end

	assign busy = count_r != '0;
	assign done = count_r == CNT_W'(1);

	timer_load_a: assert property (@(posedge sys_clk) disable iff (rst) // [RL22]
		start && !busy |=> count_r == CNT_W'(CYCLES))
		else $error("programming timer did not load its full count");
	timer_end_a: assert property (@(posedge sys_clk) disable iff (rst)
		done |=> !busy)
		else $error("programming timer still busy after done");
endmodule
`default_nettype wire

// [core/nspc_top.sv]
// Self-program controller: control/key registers, table pointer, latch and long-write sequencing
// Notes on behaviour
// (RL1) Unlock key has no storage, reads zero
// (RL2) Program select picks flash, else EEPROM
// (RL3) Config select overrides program select
// (RL4) Erase enable makes a program-space strobe erase; cleared after
// (RL5) Write permit gates writes; zero at reset
// (RL6) Abort flag set with strobe, cleared on completion
// (RL7) Write strobe starts self-timed operation, set-only
// (RL8) Completion sets sticky done flag
// (RL9) Read strobe lasts one cycle, spaces zero
// (RL10) Abort leaves space selects untouched
// (RL11) Eight-bit table latch holds moved bytes
// (RL12) Pointer is 22 bits from three bytes
// (RL13) Four pointer modes, touching low 21 bits
// (RL14) Table read uses full pointer
// (RL15) Table write fills holding register by low bits
// (RL16) Program write uses pointer block address
// (RL17) Erase uses pointer bits 21 to 6
// (RL18) Software writes 55h then AAh first
// (RL19) Write block 16 bytes, erase block 64
// (RL20) Holding registers reset to FFh after program writes
// (RL21) Core stalls during long write or erase
// (RL22) Programming time is a build parameter
`timescale 1ns/1ps
`default_nettype none
module nspc_top import nspc_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic flashRdReq,
	output logic [21:0] flashRdAddr,
	input wire logic [7:0] flashRdData,
	output logic eeRdReq,
	output logic [7:0] eeRdAddr,
	input wire logic [7:0] eeRdData,
	output logic longOpReq,
	output logic longOpErase,
	output logic [1:0] longOpTarget,
	output logic [21:0] longOpAddr,
	output logic [7:0] longOpData,
	output logic [HOLD_BYTES*8-1:0] holdBlock,
	output logic cpuStall,
	output logic memDoneFlag
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	nspc_state_type state_r;
	logic ctrlPsel_r, ctrlCsel_r, ctrlFree_r, ctrlAbort_r, ctrlPermit_r, ctrlWr_r, ctrlRd_r;
	logic idleDly_r, keyFirst_r, keyArmed_r, memDone_r, opErase_r;
	logic [7:0] latch_r, longOpData_r;
	logic [PTR_W-1:0] table_pointer_r;
	logic [1:0] opTarget_r, longOpTarget_r;
	logic [31:0] prdata_r;
	logic flashRdReq_r, longOpReq_r, longOpErase_r;
	logic [21:0] flashRdAddr_r, longOpAddr_r;
	logic timerBusy, timerDone;

	nspc_hold_if hold();

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire accDone = psel && penable && pready;
	wire wrAcc = accDone && pwrite;
	wire hitCtrl = paddr == OFF_CTRL;
	wire hitKey = paddr == OFF_KEY;
	wire hitLatch = paddr == OFF_LATCH;
	wire hitPtrLo = paddr == OFF_PTR_LO;
	wire hitPtrHi = paddr == OFF_PTR_HI;
	wire hitPtrUp = paddr == OFF_PTR_UP;
	wire hitCmd = paddr == OFF_TBL_CMD;
	wire hitIrq = paddr == OFF_IRQ2;
	wire hitStat = paddr == OFF_STAT;
	wire hitAny = hitCtrl || hitKey || hitLatch || hitPtrLo || hitPtrHi || hitPtrUp || hitCmd || hitIrq || hitStat;
	wire ctrlWrite = wrAcc && hitCtrl;
	wire keyWrite = wrAcc && hitKey;
	wire irqWrite = wrAcc && hitIrq;
	wire tblGo = wrAcc && hitCmd;

	// Stall answers via pready; one idle cycle after a stall so read data is fresh
	assign pready = state_r == ST_IDLE && idleDly_r; // [RL21]
	assign pslverr = psel && penable && pready && !hitAny;

	// ----------------------------------------
	// Space selection
	// ----------------------------------------
	wire [1:0] curTarget = ctrlCsel_r ? TGT_CONFIG : (ctrlPsel_r ? TGT_PROGRAM : TGT_EEPROM); // [RL2] [RL3]
	wire [1:0] newTarget = pwdata[CTRL_CSEL] ? TGT_CONFIG : (pwdata[CTRL_PSEL] ? TGT_PROGRAM : TGT_EEPROM); // [RL3]

	// ----------------------------------------
	// Strobe acceptance
	// ----------------------------------------
	wire wrAsk = ctrlWrite && pwdata[CTRL_WR] && !ctrlWr_r;
	// Strobe only accepted after the key pair and with permit set in the same write
	wire wrStart = wrAsk && keyArmed_r && pwdata[CTRL_PERMIT]; // [RL5] [RL7] [RL18]
	wire wrImproper = wrAsk && !wrStart;
	wire rdStart = ctrlWrite && !wrImproper && pwdata[CTRL_RD] && !pwdata[CTRL_PSEL] && !pwdata[CTRL_CSEL]; // [RL9]
	wire startErase = pwdata[CTRL_FREE] && newTarget == TGT_PROGRAM; // [RL4]

	// ----------------------------------------
	// Table pointer arithmetic
	// ----------------------------------------
	wire [PTR_LOW_W-1:0] lowInc = table_pointer_r[PTR_LOW_W-1:0] + PTR_LOW_W'(1);
	wire [PTR_LOW_W-1:0] lowDec = table_pointer_r[PTR_LOW_W-1:0] - PTR_LOW_W'(1);
	wire [PTR_W-1:0] ptrInc = {table_pointer_r[PTR_W-1], lowInc}; // [RL13]
	wire [PTR_W-1:0] ptrDec = {table_pointer_r[PTR_W-1], lowDec}; // [RL13]
	wire [1:0] cmdMode = pwdata[CMD_MODE_HI:CMD_MODE_LO];
	wire cmdWrite = pwdata[CMD_DIR];
	wire [PTR_W-1:0] effPtr = cmdMode == PM_PREINC ? ptrInc : table_pointer_r; // [RL13]
	wire [PTR_W-1:0] ptrAfter = (cmdMode == PM_POSTINC || cmdMode == PM_PREINC) ? ptrInc :
		(cmdMode == PM_POSTDEC ? ptrDec : table_pointer_r); // [RL13]

	// ----------------------------------------
	// Holding registers and timer
	// ----------------------------------------
	assign hold.write_permit = tblGo && cmdWrite; // [RL15]
	assign hold.wrIdx = effPtr[HOLD_IDX_W-1:0]; // [RL15] [RL19]
	assign hold.wrData = latch_r;
	assign hold.clearAll = timerDone && opTarget_r == TGT_PROGRAM && !opErase_r; // [RL20]

	nspc_hold_regs uHold (
		.sys_clk(sys_clk),
		.rst(rst),
		.hold(hold.regs)
	);
	nspc_prog_timer #(.CYCLES(PROG_CYCLES)) uTimer (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(wrStart),
		.busy(timerBusy),
		.done(timerDone)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			idleDly_r <= 1'b0;
		end else begin
			idleDly_r <= state_r == ST_IDLE;
			case (state_r)
				ST_IDLE: begin
					if (wrStart) begin
						state_r <= ST_LONG; // [RL21]
					end else if (tblGo && !cmdWrite) begin
						state_r <= ST_READ;
					end
				end
				ST_READ: state_r <= ST_IDLE;
				ST_LONG: begin
					if (timerDone) begin
						state_r <= ST_IDLE; // [RL21]
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlPsel_r <= 1'b0;
			ctrlCsel_r <= 1'b0;
			ctrlPermit_r <= 1'b0; // [RL5]
		end else if (ctrlWrite && !wrImproper) begin
			// A refused strobe keeps the selects so the failed target stays visible
			ctrlPsel_r <= pwdata[CTRL_PSEL]; // [RL2] [RL10]
			ctrlCsel_r <= pwdata[CTRL_CSEL]; // [RL3] [RL10]
			ctrlPermit_r <= pwdata[CTRL_PERMIT]; // [RL5]
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlFree_r <= 1'b0;
		end else if (timerDone && opErase_r) begin
			ctrlFree_r <= 1'b0; // [RL4]
		end else if (ctrlWrite) begin
			ctrlFree_r <= pwdata[CTRL_FREE]; // [RL4]
		end
	end
	// Reset cannot tell a completed write from an interrupted one, so the flag comes up set
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlAbort_r <= ABORT_RESET; // [RL6]
		end else if (wrStart || wrImproper) begin
			ctrlAbort_r <= 1'b1; // [RL6]
		end else if (timerDone) begin
			ctrlAbort_r <= 1'b0; // [RL6]
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrlWr_r <= 1'b0;
			ctrlRd_r <= 1'b0;
		end else begin
			ctrlWr_r <= wrStart || (ctrlWr_r && !timerDone); // [RL7]
			ctrlRd_r <= rdStart; // [RL9]
		end
	end

	// ----------------------------------------
	// Unlock key: sequence tracking only, no data kept
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			keyFirst_r <= 1'b0;
			keyArmed_r <= 1'b0;
		end else if (wrAcc) begin
			keyFirst_r <= keyWrite && pwdata[7:0] == KEY_FIRST; // [RL1] [RL18]
			keyArmed_r <= keyWrite && pwdata[7:0] == KEY_SECOND && keyFirst_r; // [RL18]
		end
	end

	// ----------------------------------------
	// Table latch and pointer
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			latch_r <= '0;
		end else if (ctrlRd_r) begin
			latch_r <= eeRdData; // [RL9]
		end else if (state_r == ST_READ) begin
			latch_r <= flashRdData; // [RL11] [RL14]
		end else if (wrAcc && hitLatch) begin
			latch_r <= pwdata[7:0]; // [RL11]
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			table_pointer_r <= '0;
		end else if (tblGo) begin
			table_pointer_r <= ptrAfter; // [RL13]
		end else if (wrAcc && hitPtrLo) begin
			table_pointer_r[7:0] <= pwdata[7:0]; // [RL12]
		end else if (wrAcc && hitPtrHi) begin
			table_pointer_r[15:8] <= pwdata[7:0]; // [RL12]
		end else if (wrAcc && hitPtrUp) begin
			table_pointer_r[PTR_W-1:16] <= pwdata[PTR_W-17:0]; // [RL12]
		end
	end

	// ----------------------------------------
	// Memory-side requests
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flashRdReq_r <= 1'b0;
			flashRdAddr_r <= '0;
		end else begin
			flashRdReq_r <= tblGo && !cmdWrite;
			if (tblGo && !cmdWrite) begin
				flashRdAddr_r <= effPtr; // [RL14]
			end
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			longOpReq_r <= 1'b0;
			longOpErase_r <= 1'b0;
			longOpTarget_r <= TGT_EEPROM;
			longOpAddr_r <= '0;
			longOpData_r <= '0;
			opErase_r <= 1'b0;
			opTarget_r <= TGT_EEPROM;
		end else begin
			longOpReq_r <= wrStart; // [RL7]
			if (wrStart) begin
				longOpErase_r <= startErase; // [RL4]
				longOpTarget_r <= newTarget; // [RL2] [RL3]
				opErase_r <= startErase;
				opTarget_r <= newTarget;
				longOpData_r <= latch_r;
				if (startErase) begin
					longOpAddr_r <= table_pointer_r & ERASE_MASK; // [RL17]
				end else if (newTarget == TGT_PROGRAM) begin
					longOpAddr_r <= table_pointer_r & WRITE_MASK; // [RL16]
				end else begin
					longOpAddr_r <= table_pointer_r;
				end
			end
		end
	end

	// Done flag: a completion in the clearing cycle still sets it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			memDone_r <= 1'b0;
		end else if (timerDone) begin
			memDone_r <= 1'b1; // [RL8]
		end else if (irqWrite && !pwdata[IRQ2_DONE]) begin
			memDone_r <= 1'b0; // [RL8]
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	wire [7:0] ctrlView = {ctrlPsel_r, ctrlCsel_r, 1'b0, ctrlFree_r, ctrlAbort_r, ctrlPermit_r, ctrlWr_r, ctrlRd_r};
	wire [31:0] readMux = hitCtrl ? {24'h000000, ctrlView} :
		hitLatch ? {24'h000000, latch_r} :
		hitPtrLo ? {24'h000000, table_pointer_r[7:0]} :
		hitPtrHi ? {24'h000000, table_pointer_r[15:8]} :
		hitPtrUp ? {26'h0000000, table_pointer_r[PTR_W-1:16]} :
		hitIrq ? {31'h00000000, memDone_r} :
		hitStat ? {30'h00000000, state_r} : 32'h00000000; // [RL1]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata_r <= '0;
		end else if (psel) begin
			prdata_r <= readMux;
		end
	end

	assign prdata = prdata_r;
	assign flashRdReq = flashRdReq_r;
	assign flashRdAddr = flashRdAddr_r;
	assign eeRdReq = ctrlRd_r;
	assign eeRdAddr = table_pointer_r[7:0];
	assign longOpReq = longOpReq_r;
	assign longOpErase = longOpErase_r;
	assign longOpTarget = longOpTarget_r;
	assign longOpAddr = longOpAddr_r;
	assign longOpData = longOpData_r;
	// Bytes left at FFh leave the array byte unmodified; the array honours that
	assign holdBlock = hold.block; // [RL16] [RL20]
	assign cpuStall = state_r == ST_LONG; // [RL21]
	assign memDoneFlag = memDone_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	key_reads_zero_a: assert property (accDone && !pwrite && hitKey |-> prdata == 32'h00000000) // [RL1]
		else $error("unlock key read returned nonzero");
	config_wins_a: assert property (longOpReq && ctrlCsel_r |-> longOpTarget == TGT_CONFIG) // [RL3]
		else $error("config select did not override");
	program_sel_a: assert property (longOpReq && !ctrlCsel_r |-> longOpTarget == curTarget) // [RL2]
		else $error("program select not honoured");
	permit_gate_a: assert property ($rose(ctrlWr_r) |-> ctrlPermit_r && $past(keyArmed_r)) // [RL5]
		else $error("write started without permit and key");
	abort_with_wr_a: assert property (ctrlWr_r |-> ctrlAbort_r && cpuStall && timerBusy) // [RL6]
		else $error("abort flag or stall missing during write");
	done_flag_a: assert property (timerDone |=> memDone_r && !ctrlWr_r && !ctrlAbort_r) // [RL8]
		else $error("completion did not update flags");
	erase_clear_a: assert property (timerDone && opErase_r |=> !ctrlFree_r) // [RL4]
		else $error("erase enable not cleared after erase");
	rd_pulse_a: assert property (ctrlRd_r |-> !ctrlPsel_r && !ctrlCsel_r ##1 !ctrlRd_r) // [RL9]
		else $error("read strobe longer than a cycle or wrong space");
	ptr_top_kept_a: assert property (tblGo |=> table_pointer_r[PTR_W-1] == $past(table_pointer_r[PTR_W-1])) // [RL13]
		else $error("pointer update touched top bit");
	refused_sel_a: assert property (wrImproper |=> ctrlPsel_r == $past(ctrlPsel_r) && ctrlCsel_r == $past(ctrlCsel_r)) // [RL10]
		else $error("space selects changed on refused write");
endmodule
`default_nettype wire

// [verification/nspc_mem_model.sv]
// Far-side memory model: answers table reads of flash and EEPROM reads
`timescale 1ns/1ps
`default_nettype none
module nspc_mem_model (
	input wire logic flashRdReq,
	input wire logic [21:0] flashRdAddr,
	output logic [7:0] flashRdData,
	input wire logic eeRdReq,
	input wire logic [7:0] eeRdAddr,
	output logic [7:0] eeRdData
);
	// Byte depends on all pointer bits; inverted outside a request so stale data never matches
	wire logic [7:0] flashByte = flashRdAddr[7:0] ^ flashRdAddr[15:8] ^ {2'h0, flashRdAddr[21:16]} ^ 8'h3c;
	wire logic [7:0] eeByte = eeRdAddr ^ 8'h5a;
	assign flashRdData = flashRdReq ? flashByte : ~flashByte;
	assign eeRdData = eeRdReq ? eeByte : ~eeByte;
endmodule
`default_nettype wire

// [verification/nvm_self_program_ctrl_test.sv]
// Testbench: register-level checks of the self-program controller
`timescale 1ns/1ps
`default_nettype none
module nvm_self_program_ctrl_test;
	import nspc_pkg::*;
	localparam int unsigned PC = 20;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, flashRdReq, eeRdReq, longOpReq, longOpErase, cpuStall, memDoneFlag, capErase;
	logic [21:0] flashRdAddr, longOpAddr, capAddr;
	logic [7:0] flashRdData, eeRdData, eeRdAddr, longOpData, capData;
	logic [1:0] longOpTarget, capTgt;
	logic [HOLD_BYTES*8-1:0] holdBlock;
	logic [21:0] ra [4] = '{22'h3fffff, 22'h3fffff, 22'h3fffff, 22'h200000};
	logic [21:0] pa [4] = '{22'h3fffff, 22'h200000, 22'h3ffffe, 22'h200000};
	logic [7:0] lc [5] = '{8'h80, 8'h00, 8'hc0, 8'h40, 8'h90};
	logic [1:0] lt [5] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h1};
	logic [21:0] la [5] = '{22'h3fff30, 22'h3fff3a, 22'h3fff3a, 22'h3fff3a, 22'h3fff00};
	int fails = 0;
	int comparisons = 0;
	always #2.5 sys_clk = ~sys_clk;
	nspc_top #(.PROG_CYCLES(PC)) u_nspc_top (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flashRdReq(flashRdReq), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData), .eeRdReq(eeRdReq),
		.eeRdAddr(eeRdAddr), .eeRdData(eeRdData), .longOpReq(longOpReq), .longOpErase(longOpErase),
		.longOpTarget(longOpTarget), .longOpAddr(longOpAddr), .longOpData(longOpData), .holdBlock(holdBlock),
		.cpuStall(cpuStall), .memDoneFlag(memDoneFlag));
	nspc_mem_model u_nspc_mem_model (.flashRdReq(flashRdReq), .flashRdAddr(flashRdAddr),
		.flashRdData(flashRdData), .eeRdReq(eeRdReq), .eeRdAddr(eeRdAddr), .eeRdData(eeRdData));
	// Long-op request is a one-cycle pulse, so its qualifiers are captured here
	always @(posedge sys_clk) begin
		if (longOpReq === 1'b1) begin
			capTgt <= longOpTarget;
			capErase <= longOpErase;
			capAddr <= longOpAddr;
			capData <= longOpData;
		end
	end
	task automatic summarize;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [HOLD_BYTES*8-1:0] g, input logic [HOLD_BYTES*8-1:0] x);
		comparisons++;
		if (g !== x) begin
			fails++;
			$display("FAIL t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// One APB transfer; waits for pready under a bound, takes data at the edge that ends it
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		logic rdy;
		@(posedge sys_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		rdy = 1'b0;
		n = 0;
		while (!rdy && n < 2000) begin
			@(posedge sys_clk);
			rdy = (pready === 1'b1);
			r = prdata;
			e = pslverr;
			n++;
		end
		if (!rdy) begin
			fails++;
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, 8'h00);
		chk(r, x);
	endtask
	task automatic setp(input logic [21:0] p);
		wr(OFF_PTR_LO, p[7:0]);
		wr(OFF_PTR_HI, p[15:8]);
		wr(OFF_PTR_UP, {2'h0, p[21:16]});
	endtask
	task automatic longop(input logic [7:0] c, input logic [1:0] t, input logic [21:0] a);
		wr(OFF_CTRL, c | 8'h04);
		wr(OFF_KEY, KEY_FIRST);
		wr(OFF_KEY, KEY_SECOND);
		wr(OFF_CTRL, c | 8'h06);
		@(negedge sys_clk);
		chk(cpuStall, 1'b1);
		rd(OFF_CTRL, {24'h0, c & 8'hc0 | 8'h04});
		chk(capTgt, t);
		chk(capAddr, a);
		chk(capErase, c[4]);
		chk(capData, 8'ha5);
		chk(holdBlock, {HOLD_BYTES{HOLD_RESET}});
		chk(memDoneFlag, 1'b1);
		rd(OFF_IRQ2, 32'h1);
		wr(OFF_IRQ2, 8'h00);
		rd(OFF_IRQ2, 32'h0);
		chk(memDoneFlag, 1'b0);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(OFF_CTRL, 32'h08);
		rd(OFF_STAT, 32'h0);
		chk(holdBlock, {HOLD_BYTES{HOLD_RESET}});
		chk(memDoneFlag, 1'b0);
		wr(OFF_KEY, KEY_FIRST);
		rd(OFF_KEY, 32'h0);
		rd(8'h40, 32'h0);
		chk(e, 1'b1);
		$display("test reset done");
		// --------------------------------
		// Table reads in all pointer modes
		// --------------------------------
		for (int m = 0; m < 4; m++) begin
			setp(22'h3fffff);
			wr(OFF_TBL_CMD, 8'(m << 1));
			rd(OFF_LATCH, {24'h0, ra[m][7:0] ^ ra[m][15:8] ^ {2'h0, ra[m][21:16]} ^ 8'h3c});
			rd(OFF_PTR_LO, {24'h0, pa[m][7:0]});
			rd(OFF_PTR_HI, {24'h0, pa[m][15:8]});
			rd(OFF_PTR_UP, {26'h0, pa[m][21:16]});
		end
		$display("test table read done");
		wr(OFF_LATCH, 8'ha5);
		setp(22'h3fff3a);
		wr(OFF_TBL_CMD, 8'h01);
		@(negedge sys_clk);
		chk(holdBlock[8*10 +: 8], 8'ha5);
		chk(holdBlock[8*11 +: 8], HOLD_RESET);
		$display("test table write done");
		for (int i = 0; i < 5; i++)
			longop(lc[i], lt[i], la[i]);
		$display("test long ops done");
		// Missing permit, then missing key: strobe refused, abort raised, selects kept
		wr(OFF_KEY, KEY_FIRST);
		wr(OFF_KEY, KEY_SECOND);
		wr(OFF_CTRL, 8'h82);
		rd(OFF_CTRL, 32'h8c);
		wr(OFF_CTRL, 8'h46);
		rd(OFF_CTRL, 32'h8c);
		chk(cpuStall, 1'b0);
		$display("test refusals done");
		wr(OFF_CTRL, 8'h00);
		setp(22'h000037);
		wr(OFF_CTRL, 8'h01);
		rd(OFF_LATCH, 32'h37 ^ 32'h5a);
		apb(OFF_CTRL, 1'b0, 8'h00);
		chk(r[0], 1'b0);
		wr(OFF_LATCH, 8'h11);
		wr(OFF_CTRL, 8'h81);
		rd(OFF_LATCH, 32'h11);
		$display("test eeprom read done");
		summarize();
	end
endmodule
`default_nettype wire
